// [code_source.sv]
// Processor model driving the voltage code, kept in 12.5 mV units.
// Assumes the bench calls its tasks; changes land just after a rising edge.
`timescale 1ns/10ps

module code_source (
  input wire clock_in, // System clock
  output reg [5:0] code_out // Voltage code
);
  integer units;
  function automatic [5:0] enc(input integer v);
    enc = (v <= 87) ? 6'(87 - v) : 6'(149 - v);
  endfunction
  // One unit at a time, paced by gap clocks
  task automatic step_to(input integer v, input integer gap);
    while (units != v) begin
      units = units + ((v > units) ? 1 : -1);
      @(posedge clock_in) code_out <= enc(units);
      repeat (gap) @(posedge clock_in);
    end
  endtask
  // Direct jump; -1 and -2 give the two off codes
  task automatic jump_to(input integer v);
    units = v;
    @(posedge clock_in) code_out <= (v < 0) ? 6'(64 + v) : enc(v);
  endtask
  initial begin
    units = -1;
    code_out = 6'h3f;
  end
endmodule // code_source

// [sequencer_checker_assertions.sv]
// Checker for the reference sequencer: start gating, ramp shape, power-good, read reply.
// Assumes it is bound to the sequencer and sees only its ports.
`timescale 1ns/10ps

module sequencer_checker (
  input wire clock_in, // Clock
  input wire rst_in, // Reset
  input wire por_good_in, // Bias good
  input wire threshold_enable_in, // Threshold enable
  input wire logic_level_enable_in, // Logic enable
  input wire ov_detect_in, // Overvoltage
  input wire [7:0] output_sense_in, // Sensed output
  input wire [7:0] reference_code_out, // Reference
  input wire [3:0] sense_offset_out, // Sense offset
  input wire pwm_hiz_out, // PWM off
  input wire power_ok_out, // Power good
  input wire undervoltage_out, // Undervoltage
  input wire s_axi_arvalid, // Read address valid
  input wire s_axi_arready, // Read address ready
  input wire s_axi_rvalid // Read data valid
);
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (rst_in);
////////////////////////////////////////
  property p_por_gate;
    !por_good_in [*4] |-> pwm_hiz_out && !power_ok_out;
  endproperty
  a_por_gate: assert property (p_por_gate) else $error("running without bias");
  property p_thr_gate;
    !threshold_enable_in [*4] |-> pwm_hiz_out && !power_ok_out;
  endproperty
  a_thr_gate: assert property (p_thr_gate) else $error("running below threshold");
  property p_len_drop;
    $fell(logic_level_enable_in) |-> ##2 (pwm_hiz_out && !power_ok_out);
  endproperty
  a_len_drop: assert property (p_len_drop) else $error("logic disable ignored");
  property p_release;
    $fell(pwm_hiz_out) |-> reference_code_out >= output_sense_in;
  endproperty
  a_release: assert property (p_release) else $error("pwm released early");
  property p_step;
    $changed(reference_code_out) |-> reference_code_out == 8'h00 ||
      (reference_code_out - $past(reference_code_out)) inside {8'h01, 8'h02, 8'hff};
  endproperty
  a_step: assert property (p_step) else $error("reference jumped");
  property p_coarse;
    sense_offset_out > 4'h1 && reference_code_out > $past(reference_code_out)
      |-> reference_code_out == $past(reference_code_out) + 8'h02;
  endproperty
  a_coarse: assert property (p_coarse) else $error("early ramp step not double");
  property p_offset;
    sense_offset_out != $past(sense_offset_out) |-> sense_offset_out inside {4'h0, 4'h8} ||
      sense_offset_out == $past(sense_offset_out) - 4'h1;
  endproperty
  a_offset: assert property (p_offset) else $error("offset not ramping down");
  property p_uv;
    $rose(undervoltage_out) |-> ##[0:2] !power_ok_out;
  endproperty
  a_uv: assert property (p_uv) else $error("undervoltage kept power good");
  property p_ov;
    $rose(ov_detect_in) && power_ok_out |-> ##2 power_ok_out;
  endproperty
  a_ov: assert property (p_ov) else $error("overvoltage dropped power good");
  property p_read;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready;
  endproperty
  a_read: assert property (p_read) else $error("read answer late");
  c_ok: cover property ($rose(power_ok_out));
  c_uv: cover property ($rose(undervoltage_out));
  c_down: cover property (reference_code_out == $past(reference_code_out) - 8'h01);
endmodule // sequencer_checker

bind vid_reference_sequencer sequencer_checker u_checker (.clock_in, .rst_in, .por_good_in,
  .threshold_enable_in, .logic_level_enable_in, .ov_detect_in, .output_sense_in,
  .reference_code_out, .sense_offset_out, .pwm_hiz_out, .power_ok_out, .undervoltage_out,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid);

// [switching_timebase.v]
// Switching-cycle timebase: cycle start, six sampling ticks and a half-cycle mark.
// Assumes CYCLE_CLKS is a multiple of the sample count and of two.
`timescale 1ns/10ps
`include "vid_seq_defines.vh"

module switching_timebase #(
  parameter CYCLE_CLKS = `SW_CYCLE_CLKS,
  parameter SAMPLES = `SAMPLES_PER_CYCLE
) (
  input wire clock_in, // System clock
  input wire rst_in, // Synchronous reset, active high
  output reg cycle_tick_out, // Pulse at the start of each switching cycle
  output reg sample_tick_out, // Pulse six times per cycle
  output reg half_tick_out // Pulse at mid-cycle
);

  localparam TICK_CLKS = CYCLE_CLKS / SAMPLES;
  localparam [15:0] LAST = CYCLE_CLKS - 1;
  localparam [15:0] HALF = CYCLE_CLKS / 2;
  localparam [15:0] TICK_LAST = TICK_CLKS - 1;

  reg [15:0] phase;
  reg [15:0] tick_phase;

  always @(posedge clock_in) begin
    if (rst_in) begin
      phase <= 16'h0000;
      tick_phase <= 16'h0000;
      cycle_tick_out <= 1'b0;
      sample_tick_out <= 1'b0;
      half_tick_out <= 1'b0;
    end else begin
      phase <= (phase == LAST) ? 16'h0000 : phase + 16'h0001;
      tick_phase <= (tick_phase == TICK_LAST || phase == LAST) ? 16'h0000 :
                    tick_phase + 16'h0001;
      cycle_tick_out <= (phase == LAST);
      sample_tick_out <= (tick_phase == TICK_LAST || phase == LAST);
      half_tick_out <= (phase == HALF - 16'h0001);
    end
  end

endmodule // switching_timebase

// [testbench.sv]
// Bench for the reference sequencer: gating, soft-start, code steps, faults, bus.
// Assumes the sequencer with a short switching cycle and the code source model.
`timescale 1ns/10ps
`include "vid_seq_defines.vh"

module testbench;
  localparam integer CY = 12;
  reg clock_in, rst_in, por_good_in, threshold_enable_in, logic_level_enable_in, ov_detect_in;
  reg [7:0] output_sense_in;
  wire [5:0] voltage_code_in;
  wire [7:0] reference_code_out;
  wire [3:0] sense_offset_out;
  wire pwm_hiz_out, ov_level_shutdown_out, power_ok_out, power_ok_oe_n_out, undervoltage_out;
  reg [3:0] s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
  reg [31:0] s_axi_wdata;
  reg s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  integer error_cnt, n_checks, i;
  reg [31:0] q;
  reg [1:0] r;

  vid_reference_sequencer #(.CYCLE_CLKS(CY)) dut (.clock_in, .rst_in, .voltage_code_in,
    .por_good_in, .threshold_enable_in, .logic_level_enable_in, .output_sense_in,
    .ov_detect_in, .reference_code_out, .sense_offset_out, .pwm_hiz_out,
    .ov_level_shutdown_out, .power_ok_out, .power_ok_oe_n_out, .undervoltage_out,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready);
  code_source cpu (.clock_in, .code_out(voltage_code_in));

  always #50 clock_in = ~clock_in;
////////////////////////////////////////
  task automatic chk(input [31:0] seen, input [31:0] exp, input string msg);
    n_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t %s: seen %h expected %h", $time, msg, seen, exp);
    end
  endtask
  task automatic pause(input integer n);
    repeat (n) @(negedge clock_in);
  endtask
  // One bus transfer; leaves read data in q and the response in r
  task automatic bus(input bit wr, input [3:0] a, input [31:0] d);
    integer t;
    bit done;
    done = 0;
    @(posedge clock_in);
    if (wr) begin
      s_axi_awaddr <= a; s_axi_wdata <= d; s_axi_awvalid <= 1; s_axi_wvalid <= 1; s_axi_bready <= 1;
    end else begin
      s_axi_araddr <= a; s_axi_arvalid <= 1; s_axi_rready <= 1;
    end
    for (t = 0; t < 50 && !done; t++) begin
      @(posedge clock_in);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 0;
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 0;
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bready <= 0; r = s_axi_bresp; done = 1;
      end
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rready <= 0; r = s_axi_rresp; q = s_axi_rdata; done = 1;
      end
    end
    chk(done, 1, "bus answer");
  endtask
  // Soft-start with a pre-biased output below the target
  task automatic soft_start(input integer tgt);
    integer n, c2, c1, first, rel;
    reg [7:0] prev;
    c2 = 0; c1 = 0; first = 0; rel = 0;
    @(posedge clock_in);
    output_sense_in <= 8'(tgt - 10);
    prev = reference_code_out;
    for (n = 0; n < 30000 && power_ok_out !== 1'b1; n++) begin
      @(negedge clock_in);
      if (reference_code_out == prev + 8'h02) c2++;
      if (reference_code_out == prev + 8'h01) c1++;
      if (first == 0 && reference_code_out > prev) first = n;
      if (rel == 0 && pwm_hiz_out === 1'b0) rel = reference_code_out;
      if (n == 66 * CY) chk(sense_offset_out, 8, "start offset");
      prev = reference_code_out;
    end
    chk(c2, 20, "coarse steps");
    chk(c1, tgt - 40, "fine steps");
    chk(first >= 64 * CY && first <= 100 * CY, 1, "start delay");
    chk(n >= (16 * tgt + 32) * CY && n <= (16 * tgt + 96) * CY, 1, "ramp time");
    chk(rel >= tgt - 10 && rel <= tgt - 8, 1, "release level");
    pause(2);
    chk(reference_code_out, tgt, "target");
    chk(sense_offset_out, 0, "offset done");
    chk({power_ok_out, power_ok_oe_n_out}, 2'b11, "power good");
  endtask
  task end_sim;
    if (error_cnt == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
////////////////////////////////////////
  initial begin
    clock_in = 0; rst_in = 1; por_good_in = 0; threshold_enable_in = 0;
    logic_level_enable_in = 0; ov_detect_in = 0; output_sense_in = 8'h1e;
    s_axi_awaddr = 4'h0; s_axi_araddr = 4'h0; s_axi_wdata = 32'h0000_0000;
    s_axi_wstrb = 4'hf;
    s_axi_awvalid = 0; s_axi_wvalid = 0; s_axi_bready = 0; s_axi_arvalid = 0; s_axi_rready = 0;
    error_cnt = 0; n_checks = 0; q = 0; r = 0;
    repeat (10) @(posedge clock_in);
    rst_in <= 0;
    pause(2);
    chk({pwm_hiz_out, power_ok_out, reference_code_out}, 10'h200, "reset state");
    cpu.jump_to(67);
    for (i = 0; i < 4; i++) begin
      // Off code must be sampled before the last enable rises
      if (i == 3) begin
        cpu.jump_to(-2);
        pause(CY);
      end
      @(posedge clock_in);
      {por_good_in, threshold_enable_in, logic_level_enable_in} <= 3'b111 & ~(3'b100 >> i);
      pause(8 * CY);
      bus(0, `REG_STATUS, 0);
      chk(q[7:0], 8'h10, "held in shutdown");
    end
    cpu.jump_to(67);
    soft_start(67);
    chk(ov_level_shutdown_out, 0, "run trip level");
    cpu.step_to(70, 5 * CY);
    pause(1);
    chk(reference_code_out, 70, "step up");
    cpu.step_to(69, 5 * CY);
    pause(1);
    chk(reference_code_out, 69, "step down");
    cpu.jump_to(75);
    pause(6);
    chk(reference_code_out < 75, 1, "large change paced");
    pause(30);
    chk(reference_code_out, 75, "large change done");
    @(posedge clock_in);
    output_sense_in <= 8'h38;
    pause(4);
    chk({power_ok_out, undervoltage_out, pwm_hiz_out}, 3'b010, "undervoltage");
    chk(reference_code_out, 75, "undervoltage keeps reference");
    @(posedge clock_in);
    output_sense_in <= 8'h39;
    pause(4);
    chk({power_ok_out, undervoltage_out}, 2'b10, "undervoltage gone");
    cpu.jump_to(-1);
    pause(CY);
    chk(pwm_hiz_out, 0, "off code wait");
    pause(3 * CY);
    chk({pwm_hiz_out, ov_level_shutdown_out, power_ok_out}, 3'b110, "off code");
    cpu.jump_to(90);
    soft_start(90);
    @(posedge clock_in);
    ov_detect_in <= 1;
    pause(4);
    chk({pwm_hiz_out, power_ok_out}, 2'b11, "overvoltage halt");
    cpu.jump_to(-1);
    pause(4 * CY);
    @(posedge clock_in);
    ov_detect_in <= 0;
    cpu.jump_to(90);
    pause(4 * CY);
    bus(0, `REG_STATUS, 0);
    chk(q[7:0], 8'hb5, "halt survives codes");
    @(posedge clock_in);
    logic_level_enable_in <= 0;
    pause(4);
    chk(power_ok_out, 0, "disable drops power good");
    cpu.jump_to(118);
    @(posedge clock_in);
    logic_level_enable_in <= 1;
    soft_start(118);
    bus(1, `REG_CONTROL, 1);
    chk(r, `RESP_OKAY, "control write");
    pause(4);
    chk({power_ok_out, pwm_hiz_out}, 2'b01, "soft disable");
    bus(0, `REG_CONTROL, 0);
    chk(q, 1, "control readback");
    s_axi_wstrb <= 4'h0;
    bus(1, `REG_CONTROL, 0);
    s_axi_wstrb <= 4'hf;
    bus(0, `REG_CONTROL, 0);
    chk(q, 1, "masked write ignored");
    bus(1, 4'h8, 5);
    chk(r, `RESP_SLVERR, "unmapped write");
    bus(0, 4'hc, 0);
    chk(r, `RESP_SLVERR, "unmapped read response");
    chk(q, 32'h0000_0000, "unmapped read data");
    bus(1, `REG_CONTROL, 0);
    end_sim;
  end
  initial begin
    repeat (90000) @(posedge clock_in);
    error_cnt++;
    end_sim;
  end
endmodule // testbench

// [vid_reference_sequencer.v]
// Voltage-code reference sequencer: enable gating, soft-start, code stepping,
// power-good and undervoltage flagging, with an AXI4-Lite register slave.
// Assumes all inputs are synchronous to clock_in; sense input is in 12.5 mV units.
`timescale 1ns/10ps
`include "vid_seq_defines.vh"

module vid_reference_sequencer #(
  parameter CYCLE_CLKS = `SW_CYCLE_CLKS
) (
  input wire clock_in, // System clock, 10 MHz
  input wire rst_in, // Synchronous reset, active high
  input wire [5:0] voltage_code_in, // Voltage identification code
  input wire por_good_in, // Bias above power-on-reset threshold
  input wire threshold_enable_in, // Threshold-enable comparator output
  input wire logic_level_enable_in, // Logic-level enable
  input wire [7:0] output_sense_in, // Sensed output, 12.5 mV units
  input wire ov_detect_in, // Overvoltage comparator output
  output reg [7:0] reference_code_out, // Internal reference, 12.5 mV units
  output reg [3:0] sense_offset_out, // Remote-sense offset, 12.5 mV units
  output reg pwm_hiz_out, // High: phase PWM outputs high impedance
  output reg ov_level_shutdown_out, // High: overvoltage trip at shutdown level
  output reg power_ok_out, // Power-good level, high when good
  output reg power_ok_oe_n_out, // Low while the pin is pulled low
  output reg undervoltage_out, // Undervoltage flag
  input wire [3:0] s_axi_awaddr, // Write address
  input wire s_axi_awvalid, // Write address valid
  output reg s_axi_awready, // Write address ready
  input wire [31:0] s_axi_wdata, // Write data
  input wire [3:0] s_axi_wstrb, // Write byte strobes
  input wire s_axi_wvalid, // Write data valid
  output reg s_axi_wready, // Write data ready
  output reg [1:0] s_axi_bresp, // Write response
  output reg s_axi_bvalid, // Write response valid
  input wire s_axi_bready, // Write response ready
  input wire [3:0] s_axi_araddr, // Read address
  input wire s_axi_arvalid, // Read address valid
  output reg s_axi_arready, // Read address ready
  output reg [31:0] s_axi_rdata, // Read data
  output reg [1:0] s_axi_rresp, // Read response
  output reg s_axi_rvalid, // Read data valid
  input wire s_axi_rready // Read data ready
);

  localparam [2:0] ST_SHUT = 3'h0;
  localparam [2:0] ST_DELAY = 3'h1;
  localparam [2:0] ST_RAMP = 3'h2;
  localparam [2:0] ST_RUN = 3'h3;
  localparam [2:0] ST_OFFWAIT = 3'h4;
  localparam [2:0] ST_OVHALT = 3'h5;

  localparam [10:0] DELAY_LAST = `SS_DELAY_CYCLES - 1;
  localparam [10:0] COARSE_END = `SS_COARSE_CYCLES;
  localparam [10:0] COARSE_MASK = `SS_COARSE_PERIOD - 1;
  localparam [10:0] FINE_MASK = `SS_FINE_PERIOD - 1;
  localparam [6:0] OFFSET_LAST = `SS_OFFSET_PERIOD - 1;
  localparam [1:0] OFF_LAST = `OFF_DELAY_CYCLES - 1;

  // Code to level in 12.5 mV units; off codes give zero
  function [7:0] decode_code;
    input [5:0] code;
    begin
      if (code == `OFF_CODE_A || code == `OFF_CODE_B)
        decode_code = 8'h00;
      else if (code <= 6'h14)
        decode_code = 8'h57 - {2'b00, code};
      else
        decode_code = 8'h95 - {2'b00, code};
    end
  endfunction

  function is_off_code;
    input [5:0] code;
    begin
      is_off_code = (code == `OFF_CODE_A) || (code == `OFF_CODE_B);
    end
  endfunction

  wire cycle_tick;
  wire sample_tick;
  wire half_tick;

  switching_timebase #(
    .CYCLE_CLKS(CYCLE_CLKS),
    .SAMPLES(`SAMPLES_PER_CYCLE)
  ) u_timebase (
    .clock_in(clock_in),
    .rst_in(rst_in),
    .cycle_tick_out(cycle_tick),
    .sample_tick_out(sample_tick),
    .half_tick_out(half_tick)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Register file
  reg [31:0] control;
  reg [3:0] aw_addr;
  reg aw_got;
  reg [31:0] w_data;
  reg [3:0] w_strb;
  reg w_got;
  reg [2:0] state;
  reg [5:0] code_sample;
  reg ov_latched;

  wire soft_disable = control[`CTRL_SOFT_DISABLE];
  wire [7:0] target = decode_code(code_sample);

  always @(posedge clock_in) begin
    if (rst_in) begin
      control <= `CONTROL_RESET;
      aw_addr <= 4'h0;
      aw_got <= 1'b0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      w_got <= 1'b0;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_addr <= s_axi_awaddr;
        aw_got <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
        w_got <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (aw_got && w_got && !s_axi_bvalid) begin
        aw_got <= 1'b0;
        w_got <= 1'b0;
        s_axi_bvalid <= 1'b1;
        if (aw_addr == `REG_CONTROL) begin
          s_axi_bresp <= `RESP_OKAY;
          if (w_strb[0])
            control <= {31'h0000_0000, w_data[0]};
        end else if (aw_addr == `REG_STATUS) begin
          s_axi_bresp <= `RESP_OKAY;
        end else begin
          s_axi_bresp <= `RESP_SLVERR;
        end
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        if (s_axi_araddr == `REG_CONTROL) begin
          s_axi_rdata <= control;
          s_axi_rresp <= `RESP_OKAY;
        end else if (s_axi_araddr == `REG_STATUS) begin
          s_axi_rdata <= {target, reference_code_out, 2'b00, code_sample,
                          ov_latched, undervoltage_out, power_ok_out, pwm_hiz_out,
                          1'b0, state};
          s_axi_rresp <= `RESP_OKAY;
        end else begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= `RESP_SLVERR;
        end
      end
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Sequencer
  reg [10:0] ss_count;
  reg [6:0] offset_count;
  reg [1:0] off_count;
  reg step_pending;
  reg pending_up;
  reg pwm_released;

  wire enables_ok = por_good_in && threshold_enable_in && logic_level_enable_in &&
                    !soft_disable;
  wire code_off = is_off_code(code_sample);
  wire ref_below = reference_code_out < target;
  wire ref_above = reference_code_out > target;
  wire [7:0] diff_mag = ref_below ? target - reference_code_out :
                        reference_code_out - target;
  wire [9:0] sense_x4 = {output_sense_in, 2'b00};
  wire [9:0] target_x3 = {2'b00, target} + {1'b0, target, 1'b0};
  wire uv_now = sense_x4 < target_x3;
  wire [7:0] coarse_next = reference_code_out + `STEP_COARSE;

  always @(posedge clock_in) begin
    if (rst_in) begin
      state <= ST_SHUT;
      code_sample <= `OFF_CODE_A;
      ov_latched <= 1'b0;
      ss_count <= 11'h000;
      offset_count <= 7'h00;
      off_count <= 2'h0;
      step_pending <= 1'b0;
      pending_up <= 1'b0;
      pwm_released <= 1'b0;
      reference_code_out <= 8'h00;
      sense_offset_out <= 4'h0;
      pwm_hiz_out <= 1'b1;
      ov_level_shutdown_out <= 1'b1;
      power_ok_out <= 1'b0;
      power_ok_oe_n_out <= 1'b0;
      undervoltage_out <= 1'b0;
    end else begin
      if (sample_tick)
        code_sample <= voltage_code_in;
      if (!enables_ok) begin
        // Enable or bias loss: immediate shutdown, overvoltage latch cleared
        state <= ST_SHUT;
        ov_latched <= 1'b0;
        pwm_released <= 1'b0;
        step_pending <= 1'b0;
        reference_code_out <= 8'h00;
        sense_offset_out <= 4'h0;
        ov_level_shutdown_out <= 1'b1;
        power_ok_out <= 1'b0;
      end else begin
        if (ov_detect_in && state != ST_SHUT)
          ov_latched <= 1'b1;
        case (state)
          ST_SHUT: begin
            power_ok_out <= 1'b0;
            pwm_released <= 1'b0;
            if (!code_off && !ov_latched) begin
              state <= ST_DELAY;
              ss_count <= 11'h000;
              ov_level_shutdown_out <= 1'b0;
            end
          end
          ST_DELAY: begin
            if (code_off) begin
              state <= ST_OFFWAIT;
              off_count <= 2'h0;
            end else if (cycle_tick) begin
              if (ss_count == DELAY_LAST) begin
                state <= ST_RAMP;
                ss_count <= 11'h000;
                offset_count <= 7'h00;
                sense_offset_out <= `SS_OFFSET_START;
              end else begin
                ss_count <= ss_count + 11'h001;
              end
            end
          end
          ST_RAMP: begin
            if (reference_code_out >= output_sense_in)
              pwm_released <= 1'b1;
            if (code_off) begin
              state <= ST_OFFWAIT;
              off_count <= 2'h0;
            end else if (reference_code_out >= target) begin
              state <= ST_RUN;
              reference_code_out <= target;
              sense_offset_out <= 4'h0;
              pwm_released <= 1'b1;
              power_ok_out <= 1'b1;
            end else if (cycle_tick) begin
              ss_count <= ss_count + 11'h001;
              if (sense_offset_out != 4'h0) begin
                if (offset_count == OFFSET_LAST) begin
                  offset_count <= 7'h00;
                  sense_offset_out <= sense_offset_out - 4'h1;
                end else begin
                  offset_count <= offset_count + 7'h01;
                end
              end
              if (ss_count < COARSE_END) begin
                if ((ss_count & COARSE_MASK) == COARSE_MASK)
                  reference_code_out <= (coarse_next > target) ? target : coarse_next;
              end else if ((ss_count & FINE_MASK) == FINE_MASK) begin
                reference_code_out <= reference_code_out + `STEP_FINE;
              end
            end
          end
          ST_RUN: begin
            undervoltage_out <= uv_now;
            power_ok_out <= !uv_now;
            if (ov_detect_in) begin
              state <= ST_OVHALT;
              pwm_released <= 1'b0;
            end else if (code_off) begin
              state <= ST_OFFWAIT;
              off_count <= 2'h0;
              step_pending <= 1'b0;
            end else if (sample_tick && diff_mag > `STEP_FINE) begin
              step_pending <= 1'b0;
              reference_code_out <= ref_below ? reference_code_out + `STEP_FINE :
                                    reference_code_out - `STEP_FINE;
            end else if (step_pending && half_tick) begin
              step_pending <= 1'b0;
              if (pending_up ? ref_below : ref_above)
                reference_code_out <= pending_up ? reference_code_out + `STEP_FINE :
                                      reference_code_out - `STEP_FINE;
            end else if (sample_tick && !step_pending && diff_mag != 8'h00) begin
              step_pending <= 1'b1;
              pending_up <= ref_below;
            end
          end
          ST_OFFWAIT: begin
            power_ok_out <= 1'b0;
            if (cycle_tick) begin
              if (off_count == OFF_LAST) begin
                state <= ST_SHUT;
                ov_level_shutdown_out <= 1'b1;
                pwm_released <= 1'b0;
                reference_code_out <= 8'h00;
                sense_offset_out <= 4'h0;
              end else begin
                off_count <= off_count + 2'h1;
              end
            end
          end
          ST_OVHALT: begin
            // Only an enable or bias cycle leaves this state
            pwm_released <= 1'b0;
            undervoltage_out <= uv_now;
            power_ok_out <= !uv_now;
          end
          default: begin
            state <= ST_SHUT;
          end
        endcase
      end
      pwm_hiz_out <= !pwm_released;
      power_ok_oe_n_out <= power_ok_out;
    end
  end

endmodule // vid_reference_sequencer

// [vid_seq_defines.vh]
// Constants shared by the reference sequencer and its timebase.
// Assumes a 10 MHz system clock; one switching cycle is a whole number of clocks.
`ifndef VID_SEQ_DEFINES_VH
`define VID_SEQ_DEFINES_VH

// Timebase
`define CLOCK_HZ 10000000
`define SW_CYCLE_CLKS 60
`define SAMPLES_PER_CYCLE 6

// Reference codes, in 12.5 mV units
`define CODE_W 8
`define OFF_CODE_A 6'h3f
`define OFF_CODE_B 6'h3e
`define STEP_FINE 8'h01
`define STEP_COARSE 8'h02

// Soft-start timing, in switching cycles
`define SS_DELAY_CYCLES 64
`define SS_COARSE_CYCLES 640
`define SS_COARSE_PERIOD 32
`define SS_FINE_PERIOD 16
`define SS_OFFSET_PERIOD 80
`define SS_OFFSET_START 4'h8
`define OFF_DELAY_CYCLES 2

// Register map, byte addresses
`define REG_CONTROL 4'h0
`define REG_STATUS 4'h4
`define CTRL_SOFT_DISABLE 0
`define CONTROL_RESET 32'h0000_0000
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif
